// [core/pao_pkg.sv]
// Package: register map, field layout and reset values of the oscillator
package pao_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_SEL = 8'h04;
  localparam logic [7:0] ADDR_ACC_LOW   = 8'h08;
  localparam logic [7:0] ADDR_ACC_HIGH  = 8'h0c;
  localparam logic [7:0] ADDR_ACC_UPPER = 8'h10;
  localparam logic [7:0] ADDR_INC_LOW   = 8'h14;
  localparam logic [7:0] ADDR_INC_HIGH  = 8'h18;
  localparam logic [7:0] ADDR_INC_UPPER = 8'h1c;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_OUTPUT_BIT = 5;
  localparam int CTL_INVERT_BIT = 4;
  localparam int CTL_PULSE_BIT  = 0;
  localparam int CLK_PWS_LSB    = 5;
  localparam int CLK_PWS_MSB    = 7;
  localparam int CLK_CKS_LSB    = 0;
  localparam int CLK_CKS_MSB    = 1;
  localparam int STS_FLAG_BIT   = 0;
  localparam int ACC_W          = 20;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [19:0] INC_RESET     = 20'h00001;
  localparam logic [1:0]  CKS_FAST_OSC  = 2'h0;
  localparam logic [1:0]  CKS_SYS_CLK   = 2'h1;
  localparam logic [1:0]  CKS_LOGIC_OUT = 2'h2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// [core/pao_osc.sv]
// Phase accumulator oscillator with AXI4-Lite register slave
//
// Overview of operation
// R1: Control bit 7 enables the oscillator; zero turns it off.
// R2: Control bit 5 reads back the live oscillator output.
// R3: Control bit 4 set inverts the output; clear passes it straight.
// R4: Control bit 0 picks pulse mode; zero picks divide-by-two toggle mode.
// R5: Clock register bits 7-5 set pulse width as 2^code input clock periods.
// R6: Pulse width applies only in pulse mode, ignored in toggle mode.
// R7: Pulse width longer than overflow period means output never toggles.
// R8: Clock bits 1-0 pick input: fast oscillator, system clock, logic cell.
// R9: Accumulator is 20 bits over three bytes; upper byte bits 7-4 read 0.
// R10: Accumulator bytes read live value; no atomic multi-byte access.
// R11: Software must not write the accumulator while the oscillator runs.
// R12: Reset clears all registers except increment low bit 0, set to one.
// R13: Increment buffer loads on the falling input edge after a low write.
// R14: Software writes upper and high increment bytes before the low byte.
// R15: Unimplemented control and clock register bits read as zero.
// R16: Each rising input edge adds buffered increment; carry is overflow.
// R17: Toggle mode flips output on every overflow for fifty percent duty.
// R18: Pulse mode goes active on next rising edge, inactive after width.
// R19: Every overflow sets a sticky flag until software clears it.
// R20: Disabled oscillator holds accumulator and output at inactive level.
`timescale 1ns/1ps
`default_nettype none

module pao_osc (
  input  wire logic        ref_clk,        // System clock, 40 MHz
  input  wire logic        rst_b,          // Synchronous reset, active low
  input  wire logic        fast_osc_in,    // Internal fast oscillator
  input  wire logic        logic_cell_in,  // Logic cell output
  output logic             osc_out,        // Oscillator output, polarity set
  output logic             overflow_flag,  // Sticky overflow flag
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready    // Read data ready
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic        enable_q, invert_q, pulse_mode_q;
  logic [2:0]  pulse_width_select_q;
  logic [1:0]  input_clock_select_q;
  logic [19:0] phase_accumulator_q;
  logic [19:0] phase_increment_q;
  logic [19:0] increment_buffer_q;
  logic        load_pending_q;
  logic        raw_q, carry_q;
  logic [7:0]  width_cnt_q;
  logic        fast_s1_q, fast_s2_q, fast_s3_q;
  logic        cell_s1_q, cell_s2_q, cell_s3_q;
  logic        rise_tick, fall_tick;
  logic [20:0] sum;
  logic        wr_en, rd_en;
  logic [7:0]  wbyte;
  logic        set_flag;

  // Address match helper for byte registers on lane 0
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // Pulse width as a count of input periods minus one
  function automatic logic [7:0] width_load(input logic [2:0] code);
    width_load = 8'(({7'h00, 1'b1} << code) - 8'h01);
  endfunction

  // ----------------------------------------------------------------------
  // Input clock synchronisers and edge ticks
  // ----------------------------------------------------------------------
  // Two flops before use; the third only remembers the settled level
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
      fast_s3_q <= 1'b0;
      cell_s1_q <= 1'b0;
      cell_s2_q <= 1'b0;
      cell_s3_q <= 1'b0;
    end else begin
      fast_s1_q <= fast_osc_in;
      fast_s2_q <= fast_s1_q;
      fast_s3_q <= fast_s2_q;
      cell_s1_q <= logic_cell_in;
      cell_s2_q <= cell_s1_q;
      cell_s3_q <= cell_s2_q;
    end
  end

  // Source select; a fast oscillator above half the system rate aliases
  always_comb begin
    case (input_clock_select_q)                                      // [R8]
      pao_pkg::CKS_FAST_OSC: begin
        rise_tick = fast_s2_q & ~fast_s3_q;
        fall_tick = ~fast_s2_q & fast_s3_q;
      end
      pao_pkg::CKS_SYS_CLK: begin
        rise_tick = 1'b1;
        fall_tick = 1'b1;
      end
      pao_pkg::CKS_LOGIC_OUT: begin
        rise_tick = cell_s2_q & ~cell_s3_q;
        fall_tick = ~cell_s2_q & cell_s3_q;
      end
      default: begin
        rise_tick = 1'b0;
        fall_tick = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus write decode
  // ----------------------------------------------------------------------
  assign wr_en = s_axi_awready & s_axi_awvalid & s_axi_wvalid
                 & s_axi_wstrb[0];
  assign wbyte = s_axi_wdata[7:0];
  assign rd_en = s_axi_arready & s_axi_arvalid;
  assign sum   = {1'b0, phase_accumulator_q} + {1'b0, increment_buffer_q};
  assign set_flag = enable_q & rise_tick & sum[20];                 // [R19]

  // Control and clock select registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin                                               // [R12]
      enable_q             <= 1'b0;
      invert_q             <= 1'b0;
      pulse_mode_q         <= 1'b0;
      pulse_width_select_q <= 3'h0;
      input_clock_select_q <= 2'h0;
    end else if (wr_en) begin
      if (hit(s_axi_awaddr, pao_pkg::ADDR_CONTROL)) begin
        enable_q     <= wbyte[pao_pkg::CTL_ENABLE_BIT];            // [R1]
        invert_q     <= wbyte[pao_pkg::CTL_INVERT_BIT];            // [R3]
        pulse_mode_q <= wbyte[pao_pkg::CTL_PULSE_BIT];             // [R4]
      end
      if (hit(s_axi_awaddr, pao_pkg::ADDR_CLOCK_SEL)) begin
        pulse_width_select_q <=
          wbyte[pao_pkg::CLK_PWS_MSB:pao_pkg::CLK_PWS_LSB];         // [R5]
        input_clock_select_q <=
          wbyte[pao_pkg::CLK_CKS_MSB:pao_pkg::CLK_CKS_LSB];         // [R8]
      end
    end
  end

  // Visible increment bytes; the low write arms the buffer load
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_increment_q <= pao_pkg::INC_RESET;                      // [R12]
    end else if (wr_en) begin
      if (hit(s_axi_awaddr, pao_pkg::ADDR_INC_LOW))
        phase_increment_q[7:0] <= wbyte;
      if (hit(s_axi_awaddr, pao_pkg::ADDR_INC_HIGH))
        phase_increment_q[15:8] <= wbyte;
      if (hit(s_axi_awaddr, pao_pkg::ADDR_INC_UPPER))
        phase_increment_q[19:16] <= wbyte[3:0];
    end
  end

  // Hidden buffer: falling input edge when running, at once when stopped
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      increment_buffer_q <= pao_pkg::INC_RESET;
      load_pending_q     <= 1'b0;
    end else begin
      if (load_pending_q && (!enable_q || fall_tick))
        increment_buffer_q <= phase_increment_q;                    // [R13]
      // A fresh low write wins over the load that retires the old one
      if (wr_en && hit(s_axi_awaddr, pao_pkg::ADDR_INC_LOW))
        load_pending_q <= 1'b1;                                     // [R13]
      else if (!enable_q || fall_tick)
        load_pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------------
  // Software writes while running are undefined; the bus write wins here
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_accumulator_q <= 20'h00000;
    end else if (wr_en && hit(s_axi_awaddr, pao_pkg::ADDR_ACC_LOW)) begin
      phase_accumulator_q[7:0] <= wbyte;                            // [R11]
    end else if (wr_en && hit(s_axi_awaddr, pao_pkg::ADDR_ACC_HIGH)) begin
      phase_accumulator_q[15:8] <= wbyte;
    end else if (wr_en && hit(s_axi_awaddr, pao_pkg::ADDR_ACC_UPPER)) begin
      phase_accumulator_q[19:16] <= wbyte[3:0];                     // [R9]
    end else if (enable_q && rise_tick) begin
      phase_accumulator_q <= sum[19:0];                             // [R16]
    end
  end

  // ----------------------------------------------------------------------
  // Output shaping
  // ----------------------------------------------------------------------
  // Carry is held one input edge so pulses start on the following edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !enable_q) begin
      carry_q     <= 1'b0;                                          // [R20]
      raw_q       <= 1'b0;
      width_cnt_q <= 8'h00;
    end else if (rise_tick) begin
      carry_q <= sum[20];                                           // [R16]
      if (!pulse_mode_q) begin
        if (sum[20])
          raw_q <= ~raw_q;                                          // [R17]
      end else if (carry_q) begin
        // Retrigger keeps the output active: no toggle if width too long
        raw_q       <= 1'b1;                                    // [R18] [R7]
        width_cnt_q <= width_load(pulse_width_select_q);        // [R5] [R6]
      end else if (width_cnt_q != 8'h00) begin
        width_cnt_q <= width_cnt_q - 8'h01;
      end else begin
        raw_q <= 1'b0;                                              // [R18]
      end
    end
  end

  // Polarity is the last stage; disabled output sits at inactive level
  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      osc_out <= 1'b0;
    else
      osc_out <= (enable_q & raw_q) ^ invert_q;                 // [R3] [R20]
  end

  // Sticky overflow flag, write one to bit 0 to clear; set wins
  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      overflow_flag <= 1'b0;
    else if (set_flag)
      overflow_flag <= 1'b1;                                        // [R19]
    else if (wr_en && hit(s_axi_awaddr, pao_pkg::ADDR_STATUS)
             && wbyte[pao_pkg::STS_FLAG_BIT])
      overflow_flag <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------------
  // Address and data are taken together, one write in flight at a time
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pao_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                       & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                       & ~s_axi_bvalid;
      if (s_axi_awready && s_axi_awvalid && s_axi_wvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr > pao_pkg::ADDR_STATUS ||
                         s_axi_awaddr[1:0] != 2'h0) ?
                        pao_pkg::RESP_SLVERR : pao_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path; accumulator bytes are sampled live, not as one word
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pao_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pao_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;                               // [R15]
        case (s_axi_araddr)
          pao_pkg::ADDR_CONTROL:
            s_axi_rdata[7:0] <= {enable_q, 1'b0, osc_out,
                                 invert_q, 3'h0, pulse_mode_q}; // [R2] [R15]
          pao_pkg::ADDR_CLOCK_SEL:
            s_axi_rdata[7:0] <= {pulse_width_select_q, 3'h0,
                                 input_clock_select_q};             // [R15]
          pao_pkg::ADDR_ACC_LOW:
            s_axi_rdata[7:0] <= phase_accumulator_q[7:0];           // [R10]
          pao_pkg::ADDR_ACC_HIGH:
            s_axi_rdata[7:0] <= phase_accumulator_q[15:8];
          pao_pkg::ADDR_ACC_UPPER:
            s_axi_rdata[7:0] <= {4'h0, phase_accumulator_q[19:16]}; // [R9]
          pao_pkg::ADDR_INC_LOW:
            s_axi_rdata[7:0] <= phase_increment_q[7:0];
          pao_pkg::ADDR_INC_HIGH:
            s_axi_rdata[7:0] <= phase_increment_q[15:8];
          pao_pkg::ADDR_INC_UPPER:
            s_axi_rdata[7:0] <= {4'h0, phase_increment_q[19:16]};
          pao_pkg::ADDR_STATUS:
            s_axi_rdata[7:0] <= {7'h00, overflow_flag};
          default:
            s_axi_rresp <= pao_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// [dv/pao_osc_props.sv]
// Checker: port-level assertions for the phase accumulator oscillator
`timescale 1ns/1ps
`default_nettype none

module pao_osc_props (
  input wire logic        ref_clk,        // System clock
  input wire logic        rst_b,          // Synchronous reset, active low
  input wire logic        osc_out,        // Oscillator output
  input wire logic        overflow_flag,  // Sticky overflow flag
  input wire logic [7:0]  s_axi_awaddr,   // Write address
  input wire logic        s_axi_awvalid,  // Write address valid
  input wire logic        s_axi_awready,  // Write address ready
  input wire logic [31:0] s_axi_wdata,    // Write data
  input wire logic [3:0]  s_axi_wstrb,    // Write strobes
  input wire logic        s_axi_wvalid,   // Write data valid
  input wire logic        s_axi_wready,   // Write data ready
  input wire logic        s_axi_bvalid,   // Write response valid
  input wire logic        s_axi_bready,   // Write response ready
  input wire logic [7:0]  s_axi_araddr,   // Read address
  input wire logic        s_axi_arvalid,  // Read address valid
  input wire logic        s_axi_arready,  // Read address ready
  input wire logic [31:0] s_axi_rdata,    // Read data
  input wire logic        s_axi_rvalid,   // Read data valid
  input wire logic        s_axi_rready    // Read data ready
);
  logic [7:0] rd_addr_q;  // Register targeted by the read in flight
  logic       clr_req;    // Software write that clears the flag

  // The read answer arrives later, so keep its address for field checks
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_addr_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end

  // Flag clear request: status write with bit 0 set and low byte enabled
  assign clr_req = s_axi_awvalid && s_axi_awready && s_axi_wstrb[0] &&
                   s_axi_awaddr == pao_pkg::ADDR_STATUS && s_axi_wdata[0];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_ready_pair: assert property (s_axi_awready |-> s_axi_wready)
    else $error("write readies not paired");
  a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped early");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data unstable");
  a_flag_sticky: assert property (overflow_flag && !clr_req |=>
    overflow_flag) else $error("flag lost without clear");
  a_upper_zero: assert property (s_axi_rvalid &&
    rd_addr_q == pao_pkg::ADDR_ACC_UPPER |-> s_axi_rdata[31:4] == 28'h0)
    else $error("upper accumulator bits not zero");
  a_ctl_unused: assert property (s_axi_rvalid &&
    rd_addr_q == pao_pkg::ADDR_CONTROL |->
    !s_axi_rdata[6] && s_axi_rdata[3:1] == 3'h0)
    else $error("control unused bits set");
  a_clk_unused: assert property (s_axi_rvalid &&
    rd_addr_q == pao_pkg::ADDR_CLOCK_SEL |-> s_axi_rdata[4:2] == 3'h0)
    else $error("clock unused bits set");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=>
    !osc_out && !overflow_flag && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule

bind pao_osc pao_osc_props u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .osc_out(osc_out), .overflow_flag(overflow_flag),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// [dv/tb.sv]
// Testbench: register-level tests of the phase accumulator oscillator
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        ref_clk, rst_b, fast_osc_in, logic_cell_in, out_d;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, osc_out, overflow_flag;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q, v1;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp_q;
  logic [2:0]  div_q;
  int          error_cnt, total_checks, hi, per;
  // Rows: control, clock select, increment upper, high time, period
  logic [7:0]  t_ctl[8] = '{8'h80, 8'h81, 8'h81, 8'h91,
                            8'h80, 8'h80, 8'h81, 8'h80};
  logic [7:0]  t_clk[8] = '{8'h01, 8'h01, 8'h21, 8'h01,
                            8'he1, 8'h02, 8'h61, 8'h03};
  logic [7:0]  t_up[8]  = '{8'h08, 8'h04, 8'h04, 8'h04,
                            8'h08, 8'h08, 8'h04, 8'h08};
  int          t_hi[8]  = '{2, 1, 2, 3, 2, 8, 0, 0};
  int          t_per[8] = '{4, 4, 4, 4, 4, 16, 0, 0};

  pao_osc dut (.ref_clk(ref_clk), .rst_b(rst_b), .fast_osc_in(fast_osc_in),
    .logic_cell_in(logic_cell_in), .osc_out(osc_out),
    .overflow_flag(overflow_flag),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // ----------------------------------------------------------------------
  // Clock and slow sources
  // ----------------------------------------------------------------------
  always #12.5 ref_clk = ~ref_clk;

  // One divider feeds both sources, so their rates differ by two
  always @(posedge ref_clk) begin
    div_q         <= div_q + 3'h1;
    fast_osc_in   <= div_q[2];
    logic_cell_in <= div_q[1];
    out_d         <= osc_out;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus write; bready trails the answer by one edge so a held answer is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = pao_pkg::RESP_OKAY);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    @(posedge ref_clk);
    while (s_axi_awready !== 1'b1) @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    @(posedge ref_clk);
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // Bus read; rready trails rvalid the same way, data taken at the handshake
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge ref_clk);
    while (s_axi_arready !== 1'b1) @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    @(posedge ref_clk);
    while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
    s_axi_rready <= 1'b1;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
    rd_q  = s_axi_rdata;
    rsp_q = s_axi_rresp;
  endtask

  // High time and period of the output; a stuck pin is left to the watchdog
  task automatic measure;
    hi  = 0;
    per = 0;
    @(posedge ref_clk);
    while (!(osc_out === 1'b1 && out_d === 1'b0)) @(posedge ref_clk);
    while (osc_out === 1'b1) begin
      hi++;
      per++;
      @(posedge ref_clk);
    end
    while (osc_out !== 1'b1) begin
      per++;
      @(posedge ref_clk);
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {ref_clk, rst_b, fast_osc_in, logic_cell_in, out_d, div_q} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values of all nine words; increment low alone starts at one
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4));
      check(rd_q, (i == 5) ? 32'h1 : 32'h0);
    end
    // Unmapped and misaligned places are refused
    rd(8'h24);
    check({30'h0, rsp_q}, {30'h0, pao_pkg::RESP_SLVERR});
    rd(8'h02);
    check({30'h0, rsp_q}, {30'h0, pao_pkg::RESP_SLVERR});
    wr(8'h24, 8'hff, pao_pkg::RESP_SLVERR);
    // Unused bits stay zero; an idle inverted output rests high
    wr(pao_pkg::ADDR_CONTROL, 8'h5e);
    repeat (8) @(posedge ref_clk);
    rd(pao_pkg::ADDR_CONTROL);
    check(rd_q, 32'h30);
    check({31'h0, osc_out}, 32'h1);
    // A write without lane 0 enabled is answered but leaves the register
    s_axi_wstrb <= 4'he;
    wr(pao_pkg::ADDR_CONTROL, 8'h00);
    s_axi_wstrb <= 4'hf;
    rd(pao_pkg::ADDR_CONTROL);
    check(rd_q, 32'h30);
    wr(pao_pkg::ADDR_CLOCK_SEL, 8'hff);
    rd(pao_pkg::ADDR_CLOCK_SEL);
    check(rd_q, 32'he3);
    // Accumulator is written only while stopped, then runs and holds
    wr(pao_pkg::ADDR_ACC_UPPER, 8'hff);
    wr(pao_pkg::ADDR_ACC_LOW, 8'h45);
    rd(pao_pkg::ADDR_ACC_UPPER);
    check(rd_q, 32'h0f);
    wr(pao_pkg::ADDR_CLOCK_SEL, 8'h01);
    wr(pao_pkg::ADDR_CONTROL, 8'h80);
    wr(pao_pkg::ADDR_CONTROL, 8'h00);
    rd(pao_pkg::ADDR_ACC_LOW);
    v1 = rd_q;
    check({31'h0, v1 !== 32'h45}, 32'h1);
    repeat (10) @(posedge ref_clk);
    rd(pao_pkg::ADDR_ACC_LOW);
    check(rd_q, v1);
    // Output shape for each mode, widths 1, 2 and 8, each polarity and every clock select but the fast oscillator
    for (int i = 0; i < 8; i++) begin
      wr(pao_pkg::ADDR_CONTROL, 8'h00);
      wr(pao_pkg::ADDR_CLOCK_SEL, t_clk[i]);
      wr(pao_pkg::ADDR_INC_UPPER, t_up[i]);
      wr(pao_pkg::ADDR_INC_HIGH, 8'h00);
      wr(pao_pkg::ADDR_INC_LOW, 8'h00);
      wr(pao_pkg::ADDR_CONTROL, t_ctl[i]);
      repeat (60) @(posedge ref_clk);
      if (t_per[i] != 0) begin
        measure();
        check(hi, t_hi[i]);
        check(per, t_per[i]);
      end else begin
        v1 = {31'h0, osc_out};
        hi = 0;
        repeat (64) begin
          @(posedge ref_clk);
          hi += int'(osc_out !== v1[0]);
        end
        check(hi, 0);
      end
    end
    // Sticky overflow flag, cleared by software
    wr(pao_pkg::ADDR_CONTROL, 8'h00);
    rd(pao_pkg::ADDR_STATUS);
    check(rd_q, 32'h1);
    check({31'h0, overflow_flag}, 32'h1);
    wr(pao_pkg::ADDR_STATUS, 8'h01);
    rd(pao_pkg::ADDR_STATUS);
    check(rd_q, 32'h0);
    check({31'h0, overflow_flag}, 32'h0);
    // Double buffer on the fast source: only a low-byte write reloads
    wr(pao_pkg::ADDR_CLOCK_SEL, 8'h00);
    wr(pao_pkg::ADDR_INC_UPPER, 8'h08);
    wr(pao_pkg::ADDR_INC_LOW, 8'h00);
    wr(pao_pkg::ADDR_CONTROL, 8'h80);
    repeat (80) @(posedge ref_clk);
    wr(pao_pkg::ADDR_INC_UPPER, 8'h04);
    repeat (80) @(posedge ref_clk);
    measure();
    check(per, 32);
    wr(pao_pkg::ADDR_INC_LOW, 8'h00);
    repeat (100) @(posedge ref_clk);
    measure();
    check(hi, 32);
    check(per, 64);
    stop_test();
  end

  // Watchdog: whole run needs well under a tenth of this span
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    $display("wrong value at %0t: run did not finish", $time);
    stop_test();
  end
endmodule
`default_nettype wire
